// >>> core/tap_router_pkg.sv
// Constants, types and register map of the audio tap router.
// Assumes one 10 MHz clock and a 48 kHz sample schedule derived from it.
package tap_router_pkg;

    // Clock and sample rate
    localparam int CLK_HZ = 10_000_000;
    localparam int SAMPLE_HZ = 48_000;
    // Longest whole cycle count per sample period, rounded down
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_LAST = 8'(SAMPLE_DIV - 1);

    // Sample and tap sizes
    localparam int SAMPLE_W = 16;
    localparam int NUM_PTS = 16;
    localparam logic signed [SAMPLE_W-1:0] SMP_MAX = 16'sh7FFF;
    localparam logic signed [SAMPLE_W-1:0] SMP_MIN = -16'sh7FFF - 16'sh0001;

    // Register bus
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CFG_RX_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] CFG_MIC_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] CFG_EXT1_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] CFG_EXT2_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h14;
    localparam int CTRL_LOCK_BIT = 0;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // Tap points; code 0 means no tap
    typedef enum logic [3:0] {
        PT_NONE = 4'h0, RX_PT_ONE = 4'h1, RX_PT_TWO = 4'h2,
        RX_PT_FOUR = 4'h3, RX_PT_FIVE = 4'h4, RX_PT_SEVEN = 4'h5,
        RX_PT_TEN = 4'h6, TX_PT_THREE = 4'h7, TX_PT_FOUR = 4'h8,
        TX_PT_FIVE = 4'h9, TX_PT_EIGHT = 4'hA, TX_PT_TWELVE = 4'hB,
        TX_PT_THIRTEEN = 4'hC
    } tap_point_t;

    // Tap types
    typedef enum logic [2:0] {
        TT_NONE = 3'h0, TT_BYPASS_OUT = 3'h1, TT_SPLIT = 3'h2,
        TT_SPLICE = 3'h3, TT_BYPASS_IN = 3'h4, TT_COMBINE = 3'h5
    } tap_type_t;

    // Unmute conditions; transmit accepts only the talk-key code
    typedef enum logic [1:0] {
        UM_BUSY = 2'h0, UM_BUSY_SUB = 2'h1, UM_MUTE_OPEN = 2'h2,
        UM_EXCEPT_TX = 2'h3
    } unmute_t;
    localparam logic [1:0] UM_ON_KEY = 2'h0;

    // Transmit audio sources
    localparam logic [1:0] SRC_HEAD_MIC = 2'h0;
    localparam logic [1:0] SRC_ACC_MIC = 2'h1;
    localparam logic [1:0] SRC_INJECT = 2'h2;

    // One configuration word; bit 31 down to bit 0
    typedef struct packed {
        logic [5:0] rsvd_hi;
        logic [1:0] source;
        logic [1:0] rsvd_c;
        logic [1:0] in_unmute;
        logic rsvd_b;
        tap_type_t in_type;
        tap_point_t in_pt;
        logic [1:0] rsvd_a;
        logic [1:0] out_unmute;
        logic rsvd_0;
        tap_type_t out_type;
        tap_point_t out_pt;
    } tap_cfg_t;

    // Radio state seen by the router
    typedef struct packed {
        logic busy;
        logic sub_match;
        logic mute_open;
        logic microphone_talk_key;
        logic external_talk_key_one;
        logic external_talk_key_two;
    } radio_state_t;

    // Sample handed back into the audio path
    typedef struct packed {
        logic en;
        tap_point_t point;
        logic [SAMPLE_W-1:0] sample;
    } insert_t;

    // Active configuration set, one-hot
    typedef enum logic [3:0] {
        MODE_RX = 4'b0001, MODE_MIC = 4'b0010,
        MODE_EXT1 = 4'b0100, MODE_EXT2 = 4'b1000
    } mode_t;

endpackage

// >>> core/audio_tap_router.sv
// Audio tap router: extraction to the output converter, injection from
// the input converter, per-mode tap settings behind a small register port.
// Assumes the audio path samples and radio state come from logic on
// ref_clk; the injection converter word arrives from a pin.
//
// Summary of operation
// - Extracted samples go to converter once per 208 cycles, just above 48000/s.
// - Injection line sampled at 48 kHz into path.
// - Each talk key picks its own audio source.
// - Separate settings per mode; only active set applies.
// - Injection overwrites microphone unless both taps splice.
// - Receive tap-out points and types limited.
// - Receive tap-in only seven splice or ten.
// - Transmit tap-out points and types limited.
// - Transmit tap-in points and types limited.
// - Splice needs matching types, points and unmute.
// - Combine adds injection to receive audio.
// - Settings fixed once locked; no user change.
// - Receive unmute choices; no except-transmit with splice.
// - Transmit taps unmute only while key pressed.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module audio_tap_router (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [tap_router_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire tap_router_pkg::radio_state_t radio_state,
    input wire logic [tap_router_pkg::NUM_PTS-1:0]
        [tap_router_pkg::SAMPLE_W-1:0] path_taps,
    input wire logic [tap_router_pkg::SAMPLE_W-1:0] audio_inject_line,
    output logic inject_sample_strobe,
    output logic [tap_router_pkg::SAMPLE_W-1:0] audio_extract_line,
    output logic extract_load,
    output tap_router_pkg::insert_t path_insert,
    output logic divert_en,
    output tap_router_pkg::tap_point_t divert_point,
    output logic [1:0] tx_source_sel,
    output logic mic_overwrite
);
    import tap_router_pkg::*;

    // Out-tap point and type legality for one mode
    function automatic logic out_ok(input logic rx, input tap_cfg_t c);
        logic bo_sp;
        bo_sp = (c.out_type == TT_BYPASS_OUT) || (c.out_type == TT_SPLIT);
        if (c.out_type == TT_NONE) begin
            out_ok = 1'b1;
        end else if (rx) begin
            out_ok = (bo_sp && (c.out_pt inside {RX_PT_ONE, RX_PT_TWO,
                RX_PT_FOUR, RX_PT_FIVE, RX_PT_TEN}))
                || (c.out_pt == RX_PT_SEVEN && (bo_sp
                || c.out_type == TT_SPLICE));
        end else begin
            out_ok = (bo_sp && (c.out_pt inside {TX_PT_THREE, RX_PT_TEN}))
                || (c.out_pt == TX_PT_FOUR
                && c.out_type == TT_SPLICE);
        end
    endfunction

    // In-tap point and type legality for one mode
    function automatic logic in_ok(input logic rx, input tap_cfg_t c);
        if (c.in_type == TT_NONE) begin
            in_ok = 1'b1;
        end else if (rx) begin
            in_ok = (c.in_pt == RX_PT_SEVEN && c.in_type == TT_SPLICE)
                || (c.in_pt == RX_PT_TEN && (c.in_type == TT_BYPASS_IN
                || c.in_type == TT_COMBINE));
        end else begin
            in_ok = (c.in_type == TT_BYPASS_IN && (c.in_pt inside
                {TX_PT_THREE, TX_PT_FIVE, TX_PT_EIGHT, TX_PT_TWELVE,
                TX_PT_THIRTEEN}))
                || (c.in_pt == TX_PT_FOUR
                && c.in_type == TT_SPLICE);
        end
    endfunction

    // Whole-word legality, splice pairing and unmute choice
    function automatic logic cfg_ok(input logic rx, input tap_cfg_t c);
        logic osp;
        logic isp;
        logic pair;
        logic um;
        osp = (c.out_type == TT_SPLICE);
        isp = (c.in_type == TT_SPLICE);
        pair = (osp == isp) && (!osp || (c.in_pt == c.out_pt
            && c.in_unmute == c.out_unmute));
        if (rx) begin
            um = !(osp && c.out_unmute == UM_EXCEPT_TX);
        end else begin
            um = (c.out_type == TT_NONE || c.out_unmute == UM_ON_KEY)
                && (c.in_type == TT_NONE
                || c.in_unmute == UM_ON_KEY);
        end
        cfg_ok = out_ok(rx, c) && in_ok(rx, c) && pair && um;
    endfunction

    // Unmute condition evaluated against the radio state
    function automatic logic unmuted(input logic rx, input logic [1:0] u,
                                     input radio_state_t s, input logic key);
        if (!rx) begin
            unmuted = key;
        end else begin
            unique case (u)
                UM_BUSY: unmuted = s.busy;
                UM_BUSY_SUB: unmuted = s.busy && s.sub_match;
                UM_MUTE_OPEN: unmuted = s.mute_open;
                default: unmuted = !key;
            endcase
        end
    endfunction

    // Saturating add for combine
    function automatic logic [SAMPLE_W-1:0] sat_add(
        input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
        logic signed [SAMPLE_W:0] sum;
        sum = $signed({a[SAMPLE_W-1], a}) + $signed({b[SAMPLE_W-1], b});
        if (sum > $signed({1'b0, SMP_MAX})) begin
            sat_add = SMP_MAX;
        end else if (sum < $signed({1'b1, SMP_MIN})) begin
            sat_add = SMP_MIN;
        end else begin
            sat_add = sum[SAMPLE_W-1:0];
        end
    endfunction

    // Per-mode settings, held only in these registers
    tap_cfg_t cfg_reg [4];
    logic lock_reg; // Once set, only reset reopens the settings
    logic [31:0] rdata_reg;
    logic [DIV_W-1:0] div_reg;
    logic tick_reg; // 48 kHz enable, one cycle wide
    logic [SAMPLE_W-1:0] inj_meta_reg; // First stage, read by second only
    logic [SAMPLE_W-1:0] inj_sync_reg;
    mode_t mode_reg;
    mode_t mode_next;
    logic [SAMPLE_W-1:0] extract_reg;
    logic load_reg;
    logic strobe_reg;
    insert_t insert_reg;
    insert_t insert_next;
    logic divert_reg;
    tap_point_t divert_pt_reg;
    logic [1:0] src_reg;
    logic overwrite_reg;

    // Decoded bus accesses
    wire wr_cfg = reg_wr && !lock_reg && reg_addr[1:0] == 2'b00
        && reg_addr < CTRL_ADDR;
    wire [1:0] cfg_idx = reg_addr[3:2];
    wire wr_ctrl = reg_wr && reg_addr == CTRL_ADDR;

    // Talk key precedence: microphone, then external one, then two
    wire any_key = radio_state.microphone_talk_key
        || radio_state.external_talk_key_one
        || radio_state.external_talk_key_two;
    assign mode_next = radio_state.microphone_talk_key ? MODE_MIC
        : radio_state.external_talk_key_one ? MODE_EXT1
        : radio_state.external_talk_key_two ? MODE_EXT2
        : MODE_RX;

    // Active set, chosen only by the current mode
    wire [1:0] act_idx = mode_reg[1] ? 2'd1 : mode_reg[2] ? 2'd2
        : mode_reg[3] ? 2'd3 : 2'd0;
    wire tap_cfg_t act = cfg_reg[act_idx];
    wire act_rx = mode_reg[0];
    wire [3:0] valid_vec;
    assign valid_vec[0] = cfg_ok(1'b1, cfg_reg[0]);
    assign valid_vec[1] = cfg_ok(1'b0, cfg_reg[1]);
    assign valid_vec[2] = cfg_ok(1'b0, cfg_reg[2]);
    assign valid_vec[3] = cfg_ok(1'b0, cfg_reg[3]);
    wire act_ok = valid_vec[act_idx];

    // Unmute state of each tap in the active set
    wire out_on = act_ok && act.out_type != TT_NONE
        && unmuted(act_rx, act.out_unmute, radio_state, any_key);
    wire in_on = act_ok && act.in_type != TT_NONE
        && unmuted(act_rx, act.in_unmute, radio_state, any_key);
    wire both_splice = act.in_type == TT_SPLICE
        && act.out_type == TT_SPLICE;
    wire mic_src = act.source == SRC_HEAD_MIC || act.source == SRC_ACC_MIC;

    // Sample picked at the out point; silence while muted
    wire [SAMPLE_W-1:0] tap_sample = out_on ? path_taps[act.out_pt]
        : '0;

    // Returned sample: combine adds, bypass in and splice replace
    wire [SAMPLE_W-1:0] ret_sample = (act.in_type == TT_COMBINE)
        ? sat_add(path_taps[act.in_pt], inj_sync_reg)
        : inj_sync_reg;
    // Muted or invalid in-tap hands back nothing, point and sample too
    assign insert_next = insert_t'(in_on ? {1'b1, act.in_pt, ret_sample}
        : 21'h00000);

    // Status word: mode, validity, lock, unmute states
    wire [31:0] status_word = {21'h000000, in_on, out_on, lock_reg,
        valid_vec, mode_reg};
    wire [31:0] rd_word = (reg_addr == STATUS_ADDR) ? status_word
        : (reg_addr == CTRL_ADDR) ? {31'h00000000, lock_reg}
        : (reg_addr[1:0] == 2'b00 && reg_addr < CTRL_ADDR)
        ? cfg_reg[cfg_idx] : 32'h0000_0000;

    // Settings store; writes refused after lock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                cfg_reg[i] <= CFG_RESET;
            end
        end else if (wr_cfg) begin
            cfg_reg[cfg_idx] <= reg_wdata;
        end
    end

    // Lock bit sets and stays set until reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lock_reg <= 1'b0;
        end else if (wr_ctrl && reg_wdata[CTRL_LOCK_BIT]) begin
            lock_reg <= 1'b1;
        end
    end

    // Read data for exactly one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= reg_rd ? rd_word : 32'h0000_0000;
        end
    end

    // Sample rate divider; 208 cycles gives a rate slightly above 48 kHz
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else if (div_reg == DIV_LAST) begin
            div_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 8'h01;
            tick_reg <= 1'b0;
        end
    end

    // Converter word crosses in two stages; the converter holds it
    // steady between strobes, so no bit can be caught mid-change
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inj_meta_reg <= '0;
            inj_sync_reg <= '0;
        end else begin
            inj_meta_reg <= audio_inject_line;
            inj_sync_reg <= inj_meta_reg;
        end
    end

    // Mode follows the talk keys
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= MODE_RX;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Per-sample outputs, all updated on the 48 kHz enable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            extract_reg <= '0;
            insert_reg <= '0;
        end else if (tick_reg) begin
            extract_reg <= tap_sample;
            insert_reg <= insert_next;
        end
    end

    // Strobes mark each sample period
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            load_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            load_reg <= tick_reg;
            strobe_reg <= tick_reg;
        end
    end

    // Path control levels
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            divert_reg <= 1'b0;
            divert_pt_reg <= PT_NONE;
            src_reg <= SRC_HEAD_MIC;
            overwrite_reg <= 1'b0;
        end else begin
            // Bypass out stops the path; split leaves it untouched
            divert_reg <= out_on
                && act.out_type == TT_BYPASS_OUT;
            divert_pt_reg <= act.out_pt;
            // Receive keeps the last key's choice harmlessly
            if (!act_rx) begin
                src_reg <= act.source;
            end
            overwrite_reg <= !act_rx && mic_src && in_on
                && !both_splice;
        end
    end

    assign reg_rdata = rdata_reg;
    assign audio_extract_line = extract_reg;
    assign extract_load = load_reg;
    assign inject_sample_strobe = strobe_reg;
    assign path_insert = insert_reg;
    assign divert_en = divert_reg;
    assign divert_point = divert_pt_reg;
    assign tx_source_sel = src_reg;
    assign mic_overwrite = overwrite_reg;

endmodule

// >>> test/audio_tap_router_sva.sv
// Port checker for the audio tap router: sample pacing, held outputs,
// legal divert and insert points. Sees only top ports; bound below.
`timescale 1ns/1ps
module audio_tap_router_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire tap_router_pkg::radio_state_t radio_state,
    input wire logic inject_sample_strobe,
    input wire logic [tap_router_pkg::SAMPLE_W-1:0] audio_extract_line,
    input wire logic extract_load,
    input wire tap_router_pkg::insert_t path_insert,
    input wire logic divert_en,
    input wire tap_router_pkg::tap_point_t divert_point,
    input wire logic mic_overwrite
);
    import tap_router_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Cycles since last pulse; first pulse after reset is not timed
    logic [8:0] gap_reg;
    logic seen_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gap_reg <= 9'h000;
            seen_reg <= 1'b0;
        end else if (extract_load) begin
            gap_reg <= 9'h000;
            seen_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 9'h001;
        end
    end
    // No talk key pressed for three cycles
    sequence keys_idle_s;
        (radio_state[2:0] == 3'h0) [*3];
    endsequence
    sample_period_a:
        assert property (extract_load && seen_reg |->
            gap_reg == {1'b0, DIV_LAST})
        else $error("sample pulse period wrong");
    no_missed_a:
        assert property (seen_reg |-> gap_reg <= {1'b0, DIV_LAST})
        else $error("sample pulse missing");
    strobe_pair_a:
        assert property (extract_load == inject_sample_strobe)
        else $error("load and inject strobe apart");
    extract_hold_a:
        assert property (!extract_load |-> $stable(audio_extract_line))
        else $error("extract changed between pulses");
    insert_hold_a:
        assert property (!inject_sample_strobe |-> $stable(path_insert))
        else $error("insert changed between pulses");
    insert_point_a:
        assert property (path_insert.en |-> path_insert.point inside
            {RX_PT_SEVEN, RX_PT_TEN, TX_PT_THREE, TX_PT_FOUR, TX_PT_FIVE,
             TX_PT_EIGHT, TX_PT_TWELVE, TX_PT_THIRTEEN})
        else $error("insert at illegal point");
    divert_point_a:
        assert property (divert_en |-> divert_point inside {RX_PT_ONE,
            RX_PT_TWO, RX_PT_FOUR, RX_PT_FIVE, RX_PT_SEVEN, RX_PT_TEN,
            TX_PT_THREE})
        else $error("divert at illegal point");
    idle_overwrite_a:
        assert property (keys_idle_s |-> !mic_overwrite)
        else $error("overwrite without talk key");
    idle_divert_a:
        assert property (keys_idle_s |->
            !(divert_en && divert_point == TX_PT_THREE))
        else $error("transmit divert without talk key");
endmodule

bind audio_tap_router audio_tap_router_sva chk_u (.ref_clk, .rst,
    .radio_state, .inject_sample_strobe, .audio_extract_line, .extract_load,
    .path_insert, .divert_en, .divert_point, .mic_overwrite);

// >>> test/app_device_model.sv
// Application device on the tap lines, such as a scrambler.
// Assumes the router's load pulse marks each new extracted sample.
`timescale 1ns/1ps
module app_device_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic loop_en,
    input wire logic [tap_router_pkg::SAMPLE_W-1:0] fix_v,
    input wire logic extract_load,
    input wire logic [tap_router_pkg::SAMPLE_W-1:0] audio_extract_line,
    output logic [tap_router_pkg::SAMPLE_W-1:0] audio_inject_line
);
    import tap_router_pkg::*;
    // Loop mode returns each sample scrambled, one sample late
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            audio_inject_line <= '0;
        end else if (!loop_en) begin
            // Plain source of a level set by the bench
            audio_inject_line <= fix_v;
        end else if (extract_load) begin
            audio_inject_line <= audio_extract_line ^ 16'h00FF;
        end
    end
endmodule

// >>> test/tb.sv
// Self-checking bench for the audio tap router.
// Assumes the device model on the tap lines and the bound checker.
`timescale 1ns/1ps
module tb;
    import tap_router_pkg::*;
    `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
        n_mismatch++; $display("[ERR] %0t: got %h exp %h", $time, a, e); \
        end end
    logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, loop_en = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, rv;
    radio_state_t radio_state = '0;
    logic [NUM_PTS-1:0][SAMPLE_W-1:0] path_taps;
    logic [SAMPLE_W-1:0] audio_inject_line, audio_extract_line, v;
    logic [SAMPLE_W-1:0] fix_v = 16'h1234;
    logic inject_sample_strobe, extract_load, divert_en, mic_overwrite, m;
    insert_t path_insert;
    tap_point_t divert_point;
    logic [1:0] tx_source_sel;
    tap_cfg_t c;
    int n_mismatch = 0, comparisons = 0, cyc = 0, seed = 66478;
    tap_point_t rxo [6] = '{RX_PT_ONE, RX_PT_TWO, RX_PT_FOUR, RX_PT_FIVE,
        RX_PT_SEVEN, RX_PT_TEN};
    logic [2:0] kt [3] = '{3'h6, 3'h3, 3'h1};
    logic [1:0] ks [3] = '{SRC_INJECT, SRC_ACC_MIC, SRC_HEAD_MIC};

    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;
    // Hang guard, well above the planned run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    audio_tap_router dut_u (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .radio_state, .path_taps, .audio_inject_line,
        .inject_sample_strobe, .audio_extract_line, .extract_load,
        .path_insert, .divert_en, .divert_point, .tx_source_sel,
        .mic_overwrite);
    app_device_model dev_u (.ref_clk, .rst, .loop_en, .fix_v, .extract_load,
        .audio_extract_line, .audio_inject_line);

    // Saturating signed add, as combine should give
    function automatic logic [15:0] sat(logic [15:0] a, logic [15:0] b);
        logic [16:0] s;
        s = {a[15], a} + {b[15], b};
        if (s[16] != s[15]) return s[16] ? SMP_MIN : SMP_MAX;
        return s[15:0];
    endfunction
    // Configuration word; both taps share one unmute code
    function automatic tap_cfg_t mk(tap_point_t op, tap_type_t ot,
        tap_point_t ip, tap_type_t it, logic [1:0] u, logic [1:0] s);
        mk = '0;
        mk.out_pt = op;
        mk.out_type = ot;
        mk.in_pt = ip;
        mk.in_type = it;
        mk.out_unmute = u;
        mk.in_unmute = u;
        mk.source = s;
    endfunction
    // One write cycle
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // One read cycle; data stands only in the following cycle
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    // Third sample pulse; the first may carry old settings, hangs end
    // at the cycle guard
    task ld;
        repeat (3) @(posedge extract_load);
        @(negedge ref_clk);
    endtask
    // Fresh random samples and injection level
    task rnd;
        @(posedge ref_clk);
        foreach (path_taps[j]) path_taps[j] <= $random(seed);
        fix_v <= $random(seed);
        @(negedge ref_clk);
    endtask
    // Program one setting and compare the next settled sample
    task run(input logic [7:0] a, input tap_cfg_t cf,
        input logic [15:0] ex, input logic dv, input insert_t i);
        wr(a, cf);
        ld;
        `CHK(audio_extract_line, ex)
        `CHK(divert_en, dv)
        `CHK(path_insert, i)
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        foreach (path_taps[j]) path_taps[j] = $random(seed);
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values, then an unmapped address
        for (int a = 0; a < 5; a++) begin
            rd(8'(a * 4), rv);
            `CHK(rv, CFG_RESET)
        end
        rd(8'h20, rv);
        `CHK(rv, 32'h0)
        // Receive tap-out at each point; no signalling in use
        @(posedge ref_clk);
        radio_state.busy <= 1'b1;
        foreach (rxo[i]) begin
            rnd;
            c = mk(rxo[i], ($random(seed) & 1) ? TT_SPLIT : TT_BYPASS_OUT,
                PT_NONE, TT_NONE, UM_BUSY, SRC_HEAD_MIC);
            m = c.out_type == TT_BYPASS_OUT;
            run(CFG_RX_ADDR, c, path_taps[rxo[i]], m, '0);
            if (m) `CHK(divert_point, rxo[i])
        end
        rd(CFG_RX_ADDR, rv);
        `CHK(rv, c)
        run(CFG_RX_ADDR, mk(TX_PT_THREE, TT_SPLIT, PT_NONE, TT_NONE,
            UM_BUSY, 2'h0), 16'h0, 1'b0, '0);
        $display("test rx_out done");
        // Each receive unmute code against random radio state
        for (int u = 0; u < 4; u++) begin
            @(posedge ref_clk);
            radio_state[5:3] <= 3'($random(seed));
            @(negedge ref_clk);
            m = (u == 0) ? radio_state.busy : (u == 1) ?
                radio_state.busy & radio_state.sub_match :
                (u == 2) ? radio_state.mute_open : 1'b1;
            run(CFG_RX_ADDR, mk(RX_PT_FIVE, TT_SPLIT, PT_NONE, TT_NONE,
                2'(u), 2'h0), m ? path_taps[RX_PT_FIVE] : 16'h0, 1'b0,
                '0);
        end
        $display("test unmute done");
        // Combine at the top edge, then random; bypass-in replaces
        @(posedge ref_clk);
        radio_state.busy <= 1'b1;
        path_taps[RX_PT_TEN] <= SMP_MAX;
        fix_v <= 16'h0001;
        @(negedge ref_clk);
        c = mk(PT_NONE, TT_NONE, RX_PT_TEN, TT_COMBINE, UM_BUSY, 2'h0);
        run(CFG_RX_ADDR, c, 16'h0, 1'b0, '{1'b1, RX_PT_TEN, SMP_MAX});
        rnd;
        v = sat(path_taps[RX_PT_TEN], fix_v);
        run(CFG_RX_ADDR, c, 16'h0, 1'b0, '{1'b1, RX_PT_TEN, v});
        c.in_type = TT_BYPASS_IN;
        run(CFG_RX_ADDR, c, 16'h0, 1'b0, '{1'b1, RX_PT_TEN, fix_v});
        $display("test rx_in done");
        // Receive splice through the device, then two refused forms
        @(posedge ref_clk);
        loop_en <= 1'b1;
        v = path_taps[RX_PT_SEVEN];
        c = mk(RX_PT_SEVEN, TT_SPLICE, RX_PT_SEVEN, TT_SPLICE, UM_BUSY, 2'h0);
        run(CFG_RX_ADDR, c, v, 1'b0, '{1'b1, RX_PT_SEVEN, v ^ 16'h00FF});
        c.in_unmute = UM_MUTE_OPEN;
        run(CFG_RX_ADDR, c, 16'h0, 1'b0, '0);
        c = mk(RX_PT_SEVEN, TT_SPLICE, RX_PT_SEVEN, TT_SPLICE, UM_EXCEPT_TX,
            2'h0);
        run(CFG_RX_ADDR, c, 16'h0, 1'b0, '0);
        $display("test rx_splice done");
        // Talk keys: every source code and the overwrite flag
        @(posedge ref_clk);
        loop_en <= 1'b0;
        wr(CFG_EXT1_ADDR, mk(PT_NONE, TT_NONE, PT_NONE, TT_NONE, 2'h0, 2'h1));
        wr(CFG_EXT2_ADDR, 32'h0);
        wr(CFG_RX_ADDR, 32'h0);
        @(posedge ref_clk);
        radio_state <= 6'h04;
        for (int s = 0; s < 3; s++) begin
            c = mk(TX_PT_THREE, TT_SPLIT, TX_PT_FIVE, TT_BYPASS_IN, UM_ON_KEY,
                2'(s));
            run(CFG_MIC_ADDR, c, path_taps[TX_PT_THREE], 1'b0,
                '{1'b1, TX_PT_FIVE, fix_v});
            `CHK(tx_source_sel, 2'(s))
            `CHK(mic_overwrite, 1'(s != 2))
        end
        // Two keys at once: mic first, then external one; last external two alone
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            radio_state[2:0] <= kt[k];
            repeat (3) @(negedge ref_clk);
            `CHK(tx_source_sel, ks[k])
        end
        $display("test keys done");
        // Transmit splice, a refused bypass-out and an allowed one
        @(posedge ref_clk);
        radio_state <= 6'h04;
        loop_en <= 1'b1;
        v = path_taps[TX_PT_FOUR];
        c = mk(TX_PT_FOUR, TT_SPLICE, TX_PT_FOUR, TT_SPLICE, UM_ON_KEY, 2'h0);
        run(CFG_MIC_ADDR, c, v, 1'b0, '{1'b1, TX_PT_FOUR, v ^ 16'h00FF});
        `CHK(mic_overwrite, 1'b0)
        c = mk(TX_PT_FOUR, TT_BYPASS_OUT, PT_NONE, TT_NONE, UM_ON_KEY, 2'h0);
        run(CFG_MIC_ADDR, c, 16'h0, 1'b0, '0);
        c.out_pt = RX_PT_TEN;
        run(CFG_MIC_ADDR, c, path_taps[RX_PT_TEN], 1'b1, '0);
        // Key released: transmit settings no longer apply
        @(posedge ref_clk);
        radio_state <= 6'h00;
        ld;
        `CHK(audio_extract_line, 16'h0)
        `CHK(divert_en, 1'b0)
        $display("test tx done");
        // Lock: later writes ignored, and zero never unlocks
        wr(CTRL_ADDR, 32'h1);
        wr(CFG_RX_ADDR, 32'h0000_0021);
        wr(CTRL_ADDR, 32'h0);
        rd(CFG_RX_ADDR, rv);
        `CHK(rv, CFG_RESET)
        rd(STATUS_ADDR, rv);
        `CHK(rv[8], 1'b1)
        $display("test lock done");
        tally_and_finish;
    end
endmodule
